// >>> dv/sacc_props.sv
`timescale 1ns/1ps
// Port-level checker for the serial accumulator
module sacc_props
    import sacc_pkg::*;
(
    input wire logic             i_core_clk,
    input wire logic             i_rst,
    input wire logic             i_start,
    input wire sacc_req_s        i_req,
    input wire logic             i_acc_load,
    input wire logic [ACC_W-1:0] i_acc_value,
    input wire logic             i_pc_load,
    input wire logic [PC_W-1:0]  i_pc_value,
    input wire logic             i_flags_load,
    input wire sacc_flags_s      i_flags_value,
    input wire logic [ACC_W-1:0] o_acc,
    input wire logic [POS_W-1:0] o_position,
    input wire logic [PC_W-1:0]  o_pc,
    input wire sacc_flags_s      o_flags,
    input wire logic             o_serial_carry,
    input wire logic             o_busy,
    input wire sacc_stat_s       o_stat
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sacc_cmd_e        cmd_reg; // Command now shifting
    logic             ok_w;    // Start that will be taken
    logic             bit_w;   // Single-bit command offered
    logic             hold_w;  // Carry expected held set
    logic [POS_W-1:0] pre_w;   // Expected counter preset

    assign ok_w   = i_start && !o_busy && i_req.cmd != SACC_CMD_NONE
                    && i_req.cmd <= SACC_CMD_TWOS_COMPLEMENT_NEGATE;
    assign bit_w  = i_req.cmd inside {SACC_CMD_LOAD_SINGLE_ZERO_MASK,
                                      SACC_CMD_LOAD_SINGLE_ONE};
    assign pre_w  = bit_w ? ~i_req.pos : POS_ALL_ONES;
    assign hold_w = cmd_reg inside {SACC_CMD_LOAD_SINGLE_ZERO_MASK,
                                    SACC_CMD_LOAD_ALL_ONES};

    // Remember the command, since the request bus is not held
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
            cmd_reg <= SACC_CMD_NONE;
        else if (ok_w)
            cmd_reg <= i_req.cmd;

    sequence s_accept;
        ok_w;
    endsequence
    // Busy spans 24 shifts; completion shows as busy drops, since
    // the done pulse is registered on the last shift edge itself
    sequence s_run;
        o_busy ##23 o_busy ##1
        (!o_busy && o_stat.done && o_stat.interrupt_ok);
    endsequence

    chk_cmd_span: assert property (s_accept |=> s_run)
        else $error("command span wrong");
    chk_acc_rotate: assert property ($past(o_busy) |->
        o_acc[ACC_W-2:0] == $past(o_acc[ACC_W-1:1]))
        else $error("accumulator did not rotate");
    chk_pos_step: assert property ($past(o_busy) |->
        (o_position - $past(o_position)) == SHIFT_STEP)
        else $error("position did not step");
    chk_pos_preset: assert property (ok_w |=>
        o_position == $past(pre_w))
        else $error("position preset wrong");
    chk_carry_level: assert property (
        o_busy && cmd_reg != SACC_CMD_TWOS_COMPLEMENT_NEGATE
        |-> o_serial_carry == hold_w)
        else $error("carry level wrong");
    chk_pc_step: assert property (o_stat.done |->
        (o_pc - $past(o_pc)) == PC_STEP)
        else $error("pc did not advance");
    // The step lands as busy drops; every shift but the first must hold
    chk_pc_hold: assert property (o_busy && $past(o_busy) |->
        $stable(o_pc))
        else $error("pc moved while shifting");
    chk_flags_hold: assert property (o_busy |=> $stable(o_flags))
        else $error("flags moved while shifting");
    // A start in the last busy cycle is refused as the command ends
    chk_busy_refuse: assert property (i_start && o_busy |=>
        o_stat.refused && (o_busy || o_stat.done))
        else $error("restart while busy not refused");
endmodule

// >>> dv/sacc_seq_model.sv
`timescale 1ns/1ps
// Stand-in for the instruction sequencer in state 4
module sacc_seq_model
    import sacc_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire sacc_stat_s i_stat,
    output logic            o_start,
    output sacc_req_s       o_req
);
    // Quiet from time zero
    initial
    begin
        o_start = 1'b0;
        o_req   = '0;
    end

    // Start pulse after a chosen delay; field scrambled once taken
    task automatic pulse(input sacc_cmd_e c, input logic [4:0] p,
                         input int gap);
        repeat (gap + 1) @(negedge i_core_clk);
        o_start = 1'b1;
        o_req   = '{c, p};
        @(negedge i_core_clk);
        o_start = 1'b0;
        o_req   = '{SACC_CMD_NONE, ~p};
    endtask

    // Bounded wait for completion; a miss is reported to the caller
    task automatic wait_done(output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++)
        begin
            @(negedge i_core_clk);
            ok = (i_stat.done === 1'b1);
        end
    endtask
endmodule

// >>> dv/sacc_top_test.sv
`timescale 1ns/1ps
// Self-checking bench for the serial accumulator
module sacc_top_test
    import sacc_pkg::*;
;
    logic             core_clk;  // 20 MHz clock
    logic             rst;       // Async reset
    logic             start;     // From sequencer model
    sacc_req_s        req;       // From sequencer model
    logic             acc_ld;    // Side loads
    logic             pc_ld;
    logic             fl_ld;
    logic [ACC_W-1:0] acc_v;
    logic [PC_W-1:0]  pc_v;
    sacc_flags_s      fl_v;
    logic [ACC_W-1:0] acc;       // Design outputs
    logic [POS_W-1:0] pos;
    logic [PC_W-1:0]  pc;
    sacc_flags_s      flags;
    sacc_stat_s       stat;
    int               n_errors;
    int               checks;

    sacc_top dut_u (.i_core_clk(core_clk), .i_rst(rst),
        .i_start(start), .i_req(req), .i_acc_load(acc_ld),
        .i_acc_value(acc_v), .i_pc_load(pc_ld), .i_pc_value(pc_v),
        .i_flags_load(fl_ld), .i_flags_value(fl_v), .o_acc(acc),
        .o_position(pos), .o_pc(pc), .o_flags(flags),
        .o_serial_carry(), .o_busy(), .o_stat(stat));
    sacc_seq_model seq_u (.i_core_clk(core_clk), .i_stat(stat),
        .o_start(start), .o_req(req));

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic cmp(input logic [ACC_W-1:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Side loads of accumulator and pc, ignored by design when busy
    task automatic preload(input logic [ACC_W-1:0] a,
                           input logic [PC_W-1:0] p);
        @(negedge core_clk);
        acc_ld = 1'b1;
        pc_ld  = 1'b1;
        acc_v  = a;
        pc_v   = p;
        @(negedge core_clk);
        acc_ld = 1'b0;
        pc_ld  = 1'b0;
        acc_v  = ~a; // Scrambled once loaded
    endtask

    // One whole command, then results, pc, counter and flags
    task automatic run(input sacc_cmd_e c, input logic [4:0] p,
                       input logic [ACC_W-1:0] a, exp);
        logic [PC_W-1:0]  pc0;
        logic [POS_W-1:0] pe;
        bit               ok;
        pc0 = a[PC_W-1:0]; // All-ones start also checks pc wrap
        pe  = (c inside {SACC_CMD_LOAD_SINGLE_ZERO_MASK,
                         SACC_CMD_LOAD_SINGLE_ONE}) ? ~p : 5'h1F;
        preload(a, pc0);
        seq_u.pulse(c, p, int'(p[0]));
        seq_u.wait_done(ok);
        if (!ok)
        begin
            n_errors++;
            conclude();
        end
        else
        begin
            cmp(acc, exp);
            cmp(ACC_W'(pc), ACC_W'(PC_W'(pc0 + PC_STEP)));
            cmp(ACC_W'(pos), ACC_W'(POS_W'(pe + 5'd24)));
            cmp(ACC_W'(flags), 24'h000003);
            cmp(ACC_W'(stat.interrupt_ok), 24'h000001);
        end
    endtask

    // Selected bit cleared, rest set; selected bit set, rest clear
    task automatic t_single();
        for (int i = 0; i < 3; i++)
        begin
            run(SACC_CMD_LOAD_SINGLE_ZERO_MASK, 5'(i * 11 + i / 2),
                24'h5A5A5A, ~(24'h1 << (i * 11 + i / 2)));
            run(SACC_CMD_LOAD_SINGLE_ONE, 5'(i * 11 + i / 2),
                24'hFFFFFF, 24'h1 << (i * 11 + i / 2));
        end
    endtask

    // Whole-word clear and all-ones
    task automatic t_whole();
        run(SACC_CMD_CLEAR_ACCUMULATOR, 5'h1F, 24'hFFFFFF, 24'h0);
        run(SACC_CMD_LOAD_ALL_ONES, 5'h1F, 24'h0, 24'hFFFFFF);
    endtask

    // Two's complement over edge values
    task automatic t_negate();
        logic [ACC_W-1:0] v [5] = '{24'h1, 24'h800000, 24'h0,
                                    24'h123456, 24'hFFFFFF};
        foreach (v[i])
            run(SACC_CMD_TWOS_COMPLEMENT_NEGATE, 5'h1F, v[i],
                -v[i]);
    endtask

    // Restart and loads while busy, then the none code and undefined codes when idle
    task automatic t_refuse();
        bit ok;
        preload(24'h0, 15'h0100);
        seq_u.pulse(SACC_CMD_LOAD_ALL_ONES, 5'h1F, 0);
        seq_u.pulse(SACC_CMD_CLEAR_ACCUMULATOR, 5'h1F, 0);
        cmp(ACC_W'(stat.refused), 24'h000001);
        preload(24'h0F0F0F, 15'h0000);
        seq_u.wait_done(ok);
        cmp(ACC_W'(ok), 24'h000001);
        if (!ok)
            conclude();
        for (int c = 0; c < 8; c += (c == 0) ? 6 : 1)
        begin
            seq_u.pulse(sacc_cmd_e'(c), 5'h1F, 0);
            cmp(ACC_W'(stat.refused), 24'h000001);
        end
        cmp(acc, 24'hFFFFFF);
        cmp(ACC_W'(pc), 24'h000101);
    endtask

    // Reset, flag preload, then the scenarios
    initial
    begin
        rst      = 1'b1;
        acc_ld   = 1'b0;
        pc_ld    = 1'b0;
        fl_ld    = 1'b0;
        acc_v    = '0;
        pc_v     = '0;
        fl_v     = '{1'b1, 1'b1};
        n_errors = 0;
        checks   = 0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst   = 1'b0;
        fl_ld = 1'b1;
        @(negedge core_clk);
        fl_ld = 1'b0;
        t_single();
        t_whole();
        t_negate();
        t_refuse();
        conclude();
    end
endmodule

bind sacc_top sacc_props chk_u (.i_core_clk, .i_rst, .i_start,
    .i_req, .i_acc_load, .i_acc_value, .i_pc_load, .i_pc_value,
    .i_flags_load, .i_flags_value, .o_acc, .o_position, .o_pc,
    .o_flags, .o_serial_carry, .o_busy, .o_stat);

// >>> hdl/sacc_full_adder.sv
`timescale 1ns/1ps
// One-bit serial full adder; the carry flop lives in the caller
module sacc_full_adder
(
    input  wire logic i_a,
    input  wire logic i_b,
    input  wire logic i_carry,
    output logic      o_sum,
    output logic      o_carry
);

    // Sum is the odd parity of the three inputs
    assign o_sum   = i_a ^ i_b ^ i_carry;
    // Carry when two or more inputs are set
    assign o_carry = (i_a & i_b) | (i_a & i_carry) | (i_b & i_carry);

endmodule

// >>> hdl/sacc_pkg.sv
// Contract
// RQ1: Every command rotates accumulator right through adder.
// RQ2: Single-bit commands preset counter to inverted position.
// RQ3: Zero-mask holds carry set, other inputs off; the code drives the second input at the match position.
// RQ4: Zero-mask adds one at match, clearing bit.
// RQ5: Single-one writes zero except one at match.
// RQ6: Clear shifts 24 zeros into the accumulator.
// RQ7: All-ones holds carry set over 24 shifts.
// RQ8: Negate presets counter all ones, inverts low bit.
// RQ9: Negate adds one only on first shift.
// RQ10: Negate carry flop ripples carry between shifts.
// RQ11: Program counter advances, flags stay, interrupt allowed.
// RQ12: Exactly 24 shifts, then completion is signalled.
package sacc_pkg;

    // Datapath widths
    localparam int ACC_W = 24;
    localparam int POS_W = 5;
    localparam int PC_W  = 15;

    // Shift count per command and the last shift index
    localparam logic [POS_W-1:0] SHIFT_FIRST = 5'h00;
    localparam logic [POS_W-1:0] SHIFT_LAST  = 5'h17;
    localparam logic [POS_W-1:0] SHIFT_STEP  = 5'h01;

    // Position counter value that marks the selected bit
    localparam logic [POS_W-1:0] POS_MATCH    = 5'h1F;
    // Field that whole-word commands present, all ones
    localparam logic [POS_W-1:0] POS_ALL_ONES = 5'h1F;

    // Reset values and the program counter step
    localparam logic [ACC_W-1:0] ACC_RST  = 24'h000000;
    localparam logic [PC_W-1:0]  PC_RST   = 15'h0000;
    localparam logic [PC_W-1:0]  PC_STEP  = 15'h0001;
    localparam logic [POS_W-1:0] POS_RST  = 5'h00;

    // Commands handled by this datapath
    typedef enum logic [2:0]
    {
        SACC_CMD_NONE,
        SACC_CMD_LOAD_SINGLE_ZERO_MASK,
        SACC_CMD_LOAD_SINGLE_ONE,
        SACC_CMD_CLEAR_ACCUMULATOR,
        SACC_CMD_LOAD_ALL_ONES,
        SACC_CMD_TWOS_COMPLEMENT_NEGATE
    } sacc_cmd_e;

    // Sequencer states
    typedef enum logic [1:0]
    {
        SACC_ST_IDLE,
        SACC_ST_SHIFT
    } sacc_state_e;

    // Command request from the instruction sequencer
    typedef struct packed
    {
        sacc_cmd_e        cmd;
        logic [POS_W-1:0] pos;
    } sacc_req_s;

    // Flags that these commands must leave alone
    typedef struct packed
    {
        logic test_flag;
        logic overflow_flag;
    } sacc_flags_s;

    // Completion report towards the instruction sequencer
    typedef struct packed
    {
        logic done;
        logic interrupt_ok;
        logic refused;
    } sacc_stat_s;

endpackage

// >>> hdl/sacc_top.sv
`timescale 1ns/1ps
// Bit-serial accumulator for the single-word load and negate commands
module sacc_top
    import sacc_pkg::*;
(
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_start,
    input  wire sacc_req_s        i_req,
    input  wire logic             i_acc_load,
    input  wire logic [ACC_W-1:0] i_acc_value,
    input  wire logic             i_pc_load,
    input  wire logic [PC_W-1:0]  i_pc_value,
    input  wire logic             i_flags_load,
    input  wire sacc_flags_s      i_flags_value,
    output logic [ACC_W-1:0]      o_acc,
    output logic [POS_W-1:0]      o_position,
    output logic [PC_W-1:0]       o_pc,
    output sacc_flags_s           o_flags,
    output logic                  o_serial_carry,
    output logic                  o_busy,
    output sacc_stat_s            o_stat
);

    // Architectural and sequencing state
    sacc_state_e      state_reg;       // Sequencer state
    sacc_state_e      state_next;
    sacc_cmd_e        cmd_reg;         // Command latched at start
    logic [ACC_W-1:0] acc_reg;         // Accumulator
    logic [ACC_W-1:0] acc_next;
    logic [POS_W-1:0] pos_reg;         // Position counter
    logic [POS_W-1:0] pos_next;
    logic [POS_W-1:0] shift_cnt_reg;   // Shifts done so far
    logic [POS_W-1:0] shift_cnt_next;
    logic             carry_reg;       // Serial carry flop
    logic             carry_next;
    logic [PC_W-1:0]  pc_reg;          // Program counter
    logic [PC_W-1:0]  pc_next;
    sacc_flags_s      flags_reg;       // Test and overflow flags
    sacc_stat_s       stat_reg;        // One-cycle completion pulses
    sacc_stat_s       stat_next;

    // Command decode of the latched command
    wire is_zero_mask = (cmd_reg == SACC_CMD_LOAD_SINGLE_ZERO_MASK);
    wire is_one       = (cmd_reg == SACC_CMD_LOAD_SINGLE_ONE);
    wire is_clear     = (cmd_reg == SACC_CMD_CLEAR_ACCUMULATOR);
    wire is_all_ones  = (cmd_reg == SACC_CMD_LOAD_ALL_ONES);
    wire is_negate    = (cmd_reg == SACC_CMD_TWOS_COMPLEMENT_NEGATE);

    // Decode of the incoming request, used only at the start edge
    wire req_single = (i_req.cmd == SACC_CMD_LOAD_SINGLE_ZERO_MASK) ||
                      (i_req.cmd == SACC_CMD_LOAD_SINGLE_ONE);
    wire req_whole  = (i_req.cmd == SACC_CMD_CLEAR_ACCUMULATOR) ||
                      (i_req.cmd == SACC_CMD_LOAD_ALL_ONES) ||
                      (i_req.cmd == SACC_CMD_TWOS_COMPLEMENT_NEGATE);
    wire req_forced = (i_req.cmd == SACC_CMD_LOAD_SINGLE_ZERO_MASK) ||
                      (i_req.cmd == SACC_CMD_LOAD_ALL_ONES);
    wire req_known  = req_single || req_whole;

    // Start is taken only when idle and the command is one of ours
    wire idle       = (state_reg == SACC_ST_IDLE);
    wire shifting   = (state_reg == SACC_ST_SHIFT);
    wire take_start = idle && i_start && req_known;
    // A start while busy or with a foreign command is dropped
    wire drop_start = i_start && !take_start;

    // Counter preset: single-bit commands load the inverted field,
    // whole-word commands see an all-ones field and preset to match
    wire [POS_W-1:0] pos_preset =
        req_single ? ~i_req.pos : POS_ALL_ONES;       // [RQ2] [RQ8]

    // Position match decode steers the adder second input
    wire position_match_decode = (pos_reg == POS_MATCH);

    // Low accumulator bit leaving on this shift
    wire low_bit = acc_reg[0];

    // Adder first input: only negate uses it, with the bit inverted.
    // The other commands ignore the old contents entirely, which is
    // why they need no prior clear of the accumulator.
    wire add_a = is_negate & ~low_bit;                // [RQ8] [RQ3] [RQ5]

    // Adder second input: a one at the matching position for the
    // single-bit commands and for the first shift of negate
    wire add_b = position_match_decode &
                 (is_zero_mask | is_one | is_negate); // [RQ4] [RQ5] [RQ9]

    // Carry forced set for zero mask and all ones; cleared for
    // single one and clear, which never produce a carry
    wire carry_forced = is_zero_mask | is_all_ones;   // [RQ3] [RQ7]

    // Carry actually fed to the adder on this shift
    wire add_carry = carry_forced | (is_negate & carry_reg);

    // Adder outputs
    logic add_sum;
    logic add_carry_out;

    // Serial full adder shared by every command
    sacc_full_adder u_adder
    (
        .i_a     (add_a),
        .i_b     (add_b),
        .i_carry (add_carry),
        .o_sum   (add_sum),
        .o_carry (add_carry_out)
    );

    // Rotated accumulator: adder output enters the top bit
    wire [ACC_W-1:0] acc_rotated =
        {add_sum, acc_reg[ACC_W-1:1]};                // [RQ1] [RQ6]

    // Last shift of a command
    wire last_shift = shifting && (shift_cnt_reg == SHIFT_LAST);

    // Next sequencer state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SACC_ST_IDLE:
            begin
                // Wait for a start of a known command
                if (take_start)
                begin
                    state_next = SACC_ST_SHIFT;
                end
            end
            SACC_ST_SHIFT:
            begin
                // Leave after exactly 24 shifts
                if (last_shift)
                begin
                    state_next = SACC_ST_IDLE;        // [RQ12]
                end
            end
            default:
            begin
                // Recover from an illegal code
                state_next = SACC_ST_IDLE;
            end
        endcase
    end

    // Shift counter: cleared at start, counts every shift
    always_comb
    begin
        shift_cnt_next = shift_cnt_reg;
        if (take_start)
        begin
            shift_cnt_next = SHIFT_FIRST;
        end
        else if (shifting)
        begin
            shift_cnt_next = shift_cnt_reg + SHIFT_STEP; // [RQ12]
        end
    end

    // Position counter: preset at start, stepped on every shift
    always_comb
    begin
        pos_next = pos_reg;
        if (take_start)
        begin
            pos_next = pos_preset;                    // [RQ2] [RQ8]
        end
        else if (shifting)
        begin
            pos_next = pos_reg + SHIFT_STEP;          // [RQ2]
        end
    end

    // Carry flop: forced set, or rippling for negate, or clear
    always_comb
    begin
        carry_next = carry_reg;
        if (take_start)
        begin
            // Negate starts with no carry; forced commands start set
            carry_next = req_forced;                  // [RQ3] [RQ7]
        end
        else if (shifting)
        begin
            if (carry_forced)
            begin
                carry_next = 1'b1;                    // [RQ3] [RQ7]
            end
            else if (is_negate)
            begin
                carry_next = add_carry_out;           // [RQ10]
            end
            else
            begin
                carry_next = 1'b0;
            end
        end
    end

    // Accumulator: rotate while shifting, outside load when idle.
    // The outside load is ignored mid-command so a half-rotated
    // word is never overwritten.
    always_comb
    begin
        acc_next = acc_reg;
        if (shifting)
        begin
            acc_next = acc_rotated;                   // [RQ1]
        end
        else if (i_acc_load)
        begin
            acc_next = i_acc_value;
        end
    end

    // Program counter: one step at the end of every command
    always_comb
    begin
        pc_next = pc_reg;
        if (last_shift)
        begin
            pc_next = pc_reg + PC_STEP;               // [RQ11]
        end
        else if (i_pc_load && idle)
        begin
            pc_next = i_pc_value;
        end
    end

    // Completion pulses; interrupt window opens as command ends
    always_comb
    begin
        stat_next              = '0;
        stat_next.done         = last_shift;          // [RQ12]
        stat_next.interrupt_ok = last_shift;          // [RQ11]
        stat_next.refused      = drop_start;
    end

    // Sequencer and datapath registers
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg     <= SACC_ST_IDLE;
            shift_cnt_reg <= SHIFT_FIRST;
            pos_reg       <= POS_RST;
            carry_reg     <= 1'b0;
            acc_reg       <= ACC_RST;
        end
        else
        begin
            state_reg     <= state_next;
            shift_cnt_reg <= shift_cnt_next;
            pos_reg       <= pos_next;
            carry_reg     <= carry_next;
            acc_reg       <= acc_next;
        end
    end

    // Latched command; a foreign command never reaches here
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cmd_reg <= SACC_CMD_NONE;
        end
        else if (take_start)
        begin
            cmd_reg <= i_req.cmd;
        end
    end

    // Program counter and status pulses
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pc_reg   <= PC_RST;
            stat_reg <= '0;
        end
        else
        begin
            pc_reg   <= pc_next;
            stat_reg <= stat_next;
        end
    end

    // Flags: these commands never touch them, only an idle load does
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            flags_reg <= '0;
        end
        else if (i_flags_load && idle)
        begin
            flags_reg <= i_flags_value;               // [RQ11]
        end
    end

    // Outputs come straight from flops
    assign o_acc          = acc_reg;
    assign o_position     = pos_reg;
    assign o_pc           = pc_reg;
    assign o_flags        = flags_reg;
    assign o_serial_carry = carry_reg;
    assign o_stat         = stat_reg;

    // Busy is its own flop, loaded from the next-state decode once per edge, so it tracks the shift state
    logic busy_reg;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            busy_reg <= 1'b0;
        end
        else
        begin
            busy_reg <= (state_next == SACC_ST_SHIFT);
        end
    end
    assign o_busy = busy_reg;

endmodule
